// ---- hw/ftr_pkg.sv ----
// constants for the flash timing and auto-read register block
`default_nettype none
package ftr_pkg;
  localparam int unsigned ADDR_W = 4;
  // register indices on the cpu register port
  localparam logic [3:0] OFS_START      = 4'h0;
  localparam logic [3:0] OFS_TRAN       = 4'h1;
  localparam logic [3:0] OFS_PROG       = 4'h2;
  localparam logic [3:0] OFS_PERASE     = 4'h3;
  localparam logic [3:0] OFS_MERASE     = 4'h4;
  localparam logic [3:0] OFS_END        = 4'h5;
  localparam logic [3:0] OFS_MEND       = 4'h6;
  localparam logic [3:0] OFS_RCV        = 4'h7;
  localparam logic [3:0] OFS_PSR        = 4'h8;
  localparam logic [3:0] OFS_FUNC       = 4'h9;
  localparam logic [3:0] OFS_FUNC_ALIAS = 4'ha;
  localparam logic [3:0] OFS_PROT       = 4'hb;
  localparam logic [3:0] OFS_PROT_ALIAS = 4'hc;
  localparam logic [3:0] OFS_CODE       = 4'hd;
  localparam logic [3:0] OFS_CODE_ALIAS = 4'he;
  localparam logic [3:0] OFS_STATUS     = 4'hf;
  // reset values
  localparam logic [7:0] RST_START  = 8'h18;
  localparam logic [7:0] RST_TRAN   = 8'h30;
  localparam logic [7:0] RST_PROG   = 8'h16;
  localparam logic [7:0] RST_PERASE = 8'h04;
  localparam logic [7:0] RST_MERASE = 8'hea;
  localparam logic [7:0] RST_END    = 8'h18;
  localparam logic [7:0] RST_MEND   = 8'h3c;
  localparam logic [7:0] RST_RCV    = 8'h04;
  localparam logic [4:0] RST_DIV    = 5'h04;
  // pulse and module end delay multipliers as shift amounts
  localparam int unsigned SHIFT_PROG  = 3;
  localparam int unsigned SHIFT_ERASE = 12;
  localparam int unsigned SHIFT_MEND  = 3;
  // field positions and widths
  localparam int unsigned FUNC_USB_EN_BIT = 0;
  localparam int unsigned BOOT_LSB        = 1;
  localparam int unsigned CODE_LSB        = 9;
  localparam int unsigned BOOT_W          = 4;
  localparam int unsigned DIV_W           = 5;
  localparam int unsigned CNT_W           = 21;
  localparam int unsigned STATUS_BUSY_BIT = 2;
  // operation codes
  localparam logic [1:0] OP_PROG   = 2'h0;
  localparam logic [1:0] OP_PERASE = 2'h1;
  localparam logic [1:0] OP_MERASE = 2'h2;
  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_START = 7'b0000010,
    ST_TRAN  = 7'b0000100,
    ST_PULSE = 7'b0001000,
    ST_END   = 7'b0010000,
    ST_MEND  = 7'b0100000,
    ST_RCV   = 7'b1000000
  } ftr_state_t;
endpackage
`default_nettype wire

// ---- hw/ftr_prescaler.sv ----
// prescaler producing one-cycle ticks at the system clock over (divisor + 1)
`default_nettype none
module ftr_prescaler #(
  parameter int unsigned DIV_W = 5
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  input  wire logic             run_in,
  input  wire logic [DIV_W-1:0] divisor_in,
  output logic                  tick_out
);
  logic [DIV_W-1:0] cnt;
  wire              wrap = (cnt >= divisor_in);

  initial begin
    if (DIV_W < 1) $error("divisor width must be at least 1");
  end

  // held cleared while idle so each operation starts on a whole prescaler period
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= '0;
    end else if (!run_in || wrap) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  assign tick_out = run_in && wrap;
endmodule
`default_nettype wire

// ---- hw/ftr_phase_timer.sv ----
// down counter that ends a phase after a loaded number of prescaler ticks
`default_nettype none
module ftr_phase_timer #(
  parameter int unsigned CNT_W = 21
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  input  wire logic             load_in,
  input  wire logic [CNT_W-1:0] ticks_in,
  input  wire logic             tick_in,
  output logic                  done_out
);
  logic [CNT_W-1:0] remain;

  initial begin
    if (CNT_W < 2) $error("counter width too small");
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      remain <= '0;
    end else if (load_in) begin
      remain <= ticks_in;
    end else if (tick_in && remain != '0) begin
      remain <= remain - 1'b1;
    end
  end

  // done on the tick that spends the last count; a reload on that edge wins
  assign done_out = tick_in && (remain == {{(CNT_W-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

// ---- hw/ftr_flash_timing.sv ----
// flash program/erase timing registers, phase sequencer and auto-read copies
// Functional notes
// - start phase lasts start count plus one
// - transition phase count plus one, reset 30h
// - program pulse eight times count plus one
// - page erase pulse 4096 times count plus one
// - module erase pulse 4096 times count plus one
// - end delay count plus one, reset 18h
// - module end delay eight times count plus one
// - recovery delay count plus one between accesses
// - timing defaults load at every reset, busy or idle
// - function word sampled at reset, alias reads same
// - function bit0 zero forces transceiver low power
// - protection word sampled at reset, alias same
// - code start register loaded on the first clock after reset release
// - code start bits 8:0, 15:13 read zero
// - code start bits 12:9 inverted boot field
// - prescaler tick is clock over divisor plus one
`default_nettype none
module ftr_flash_timing (
  input  wire logic                          clk_sys_in,
  input  wire logic                          rst_n_in,
  input  wire logic [ftr_pkg::ADDR_W-1:0]    reg_addr_in,
  input  wire logic                          reg_wr_in,
  input  wire logic                          reg_rd_in,
  input  wire logic [15:0]                   reg_wdata_in,
  output logic      [15:0]                   reg_rdata_out,
  input  wire logic                          op_start_in,
  input  wire logic [1:0]                    op_kind_in,
  input  wire logic [15:0]                   info_func_word_in,
  input  wire logic [15:0]                   info_prot_word_in,
  input  wire logic                          usb_ctrl_power_in,
  output logic                               usb_xcvr_power_out,
  output logic                               flash_op_in_progress_out,
  output logic                               pulse_prog_out,
  output logic                               pulse_erase_out,
  output logic                               code_branch_valid_out,
  output logic      [15:0]                   code_area_start_out
);
  localparam int unsigned CW = ftr_pkg::CNT_W;

  ftr_pkg::ftr_state_t state;
  ftr_pkg::ftr_state_t next_state;

  logic [7:0]                  start_delay_count;
  logic [7:0]                  transition_count;
  logic [7:0]                  program_pulse_count;
  logic [7:0]                  page_erase_count;
  logic [7:0]                  module_erase_count;
  logic [7:0]                  end_delay_count;
  logic [7:0]                  module_end_delay_count;
  logic [7:0]                  recovery_delay_count;
  logic [ftr_pkg::DIV_W-1:0]   prescale_divisor;
  logic [15:0]                 function_word_copy;
  logic [15:0]                 protection_word_copy;
  logic [15:0]                 code_area_start;
  logic                        sampled;
  logic [1:0]                  op_kind;
  logic [15:0]                 rdata;

  wire busy = (state != ftr_pkg::ST_IDLE);

  // busy at reset is recorded but unused; a reset while busy still loads the default timing
  logic busy_at_reset;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_at_reset <= 1'b0;
    end else begin
      busy_at_reset <= busy;
    end
  end

  // write decode; writes while busy are dropped as a safety net
  wire wr_ok       = reg_wr_in && !busy;
  wire wr_start    = wr_ok && (reg_addr_in == ftr_pkg::OFS_START);
  wire wr_tran     = wr_ok && (reg_addr_in == ftr_pkg::OFS_TRAN);
  wire wr_prog     = wr_ok && (reg_addr_in == ftr_pkg::OFS_PROG);
  wire wr_perase   = wr_ok && (reg_addr_in == ftr_pkg::OFS_PERASE);
  wire wr_merase   = wr_ok && (reg_addr_in == ftr_pkg::OFS_MERASE);
  wire wr_end      = wr_ok && (reg_addr_in == ftr_pkg::OFS_END);
  wire wr_mend     = wr_ok && (reg_addr_in == ftr_pkg::OFS_MEND);
  wire wr_rcv      = wr_ok && (reg_addr_in == ftr_pkg::OFS_RCV);
  wire wr_psr      = wr_ok && (reg_addr_in == ftr_pkg::OFS_PSR);

  // timing registers: defaults on every reset, even when reset finds the flash busy
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      start_delay_count      <= ftr_pkg::RST_START;
      transition_count       <= ftr_pkg::RST_TRAN;
      program_pulse_count    <= ftr_pkg::RST_PROG;
      page_erase_count       <= ftr_pkg::RST_PERASE;
      module_erase_count     <= ftr_pkg::RST_MERASE;
      end_delay_count        <= ftr_pkg::RST_END;
      module_end_delay_count <= ftr_pkg::RST_MEND;
      recovery_delay_count   <= ftr_pkg::RST_RCV;
      prescale_divisor       <= ftr_pkg::RST_DIV;
    end else begin
      if (wr_start)  start_delay_count      <= reg_wdata_in[7:0];
      if (wr_tran)   transition_count       <= reg_wdata_in[7:0];
      if (wr_prog)   program_pulse_count    <= reg_wdata_in[7:0];
      if (wr_perase) page_erase_count       <= reg_wdata_in[7:0];
      if (wr_merase) module_erase_count     <= reg_wdata_in[7:0];
      if (wr_end)    end_delay_count        <= reg_wdata_in[7:0];
      if (wr_mend)   module_end_delay_count <= reg_wdata_in[7:0];
      if (wr_rcv)    recovery_delay_count   <= reg_wdata_in[7:0];
      if (wr_psr)    prescale_divisor       <= reg_wdata_in[ftr_pkg::DIV_W-1:0];
    end
  end

  // auto-read copies caught by a clocked process right after reset release
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sampled              <= 1'b0;
      function_word_copy   <= 16'h0000;
      protection_word_copy <= 16'h0000;
      code_area_start      <= 16'h0000;
    end else if (!sampled) begin
      sampled              <= 1'b1;
      function_word_copy   <= info_func_word_in;
      protection_word_copy <= info_prot_word_in;
      code_area_start      <= {3'h0,
        ~info_prot_word_in[ftr_pkg::BOOT_LSB +: ftr_pkg::BOOT_W], 9'h000};
    end
  end

  // until sampled the transceiver stays in low power, the safe side
  assign usb_xcvr_power_out = sampled && function_word_copy[ftr_pkg::FUNC_USB_EN_BIT]
                              && usb_ctrl_power_in;
  assign code_branch_valid_out = sampled;
  assign code_area_start_out   = code_area_start;

  // phase lengths in prescaler ticks
  wire [CW-1:0] len_start = CW'({1'b0, start_delay_count} + 9'h001);
  wire [CW-1:0] len_tran  = CW'({1'b0, transition_count} + 9'h001);
  wire [CW-1:0] len_prog  =
    CW'({1'b0, program_pulse_count} + 9'h001) << ftr_pkg::SHIFT_PROG;
  wire [CW-1:0] len_per   =
    CW'({1'b0, page_erase_count} + 9'h001) << ftr_pkg::SHIFT_ERASE;
  wire [CW-1:0] len_mer   =
    CW'({1'b0, module_erase_count} + 9'h001) << ftr_pkg::SHIFT_ERASE;
  wire [CW-1:0] len_end   = CW'({1'b0, end_delay_count} + 9'h001);
  wire [CW-1:0] len_mend  =
    CW'({1'b0, module_end_delay_count} + 9'h001) << ftr_pkg::SHIFT_MEND;
  wire [CW-1:0] len_rcv   = CW'({1'b0, recovery_delay_count} + 9'h001);

  wire is_merase = (op_kind == ftr_pkg::OP_MERASE);
  wire is_perase = (op_kind == ftr_pkg::OP_PERASE);
  wire [CW-1:0] len_pulse = is_merase ? len_mer : (is_perase ? len_per : len_prog);

  wire tick;
  wire done;
  wire go = (state == ftr_pkg::ST_IDLE) && op_start_in && sampled;
  wire load = go || done;

  // length of the phase that starts next
  logic [CW-1:0] next_len;
  always_comb begin
    next_len = len_start;
    unique case (next_state)
      ftr_pkg::ST_IDLE:  next_len = len_start;
      ftr_pkg::ST_START: next_len = len_start;
      ftr_pkg::ST_TRAN:  next_len = len_tran;
      ftr_pkg::ST_PULSE: next_len = len_pulse;
      ftr_pkg::ST_END:   next_len = len_end;
      ftr_pkg::ST_MEND:  next_len = len_mend;
      ftr_pkg::ST_RCV:   next_len = len_rcv;
    endcase
  end

  // phase order; module erase takes its own end delay
  always_comb begin
    next_state = state;
    unique case (state)
      ftr_pkg::ST_IDLE:  if (go) next_state = ftr_pkg::ST_START;
      ftr_pkg::ST_START: if (done) next_state = ftr_pkg::ST_TRAN;
      ftr_pkg::ST_TRAN:  if (done) next_state = ftr_pkg::ST_PULSE;
      ftr_pkg::ST_PULSE: if (done) next_state = is_merase ? ftr_pkg::ST_MEND
                                                          : ftr_pkg::ST_END;
      ftr_pkg::ST_END:   if (done) next_state = ftr_pkg::ST_RCV;
      ftr_pkg::ST_MEND:  if (done) next_state = ftr_pkg::ST_RCV;
      ftr_pkg::ST_RCV:   if (done) next_state = ftr_pkg::ST_IDLE;
      default:           next_state = ftr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state   <= ftr_pkg::ST_IDLE;
      op_kind <= ftr_pkg::OP_PROG;
    end else begin
      state <= next_state;
      if (go) op_kind <= op_kind_in;
    end
  end

  ftr_prescaler #(
    .DIV_W (ftr_pkg::DIV_W)
  ) u_prescaler (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .run_in     (busy),
    .divisor_in (prescale_divisor),
    .tick_out   (tick)
  );

  ftr_phase_timer #(
    .CNT_W (CW)
  ) u_timer (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .load_in    (load),
    .ticks_in   (next_len),
    .tick_in    (tick),
    .done_out   (done)
  );

  // timer reloads with the next phase length on every boundary
  assign flash_op_in_progress_out = busy;
  assign pulse_prog_out  = (state == ftr_pkg::ST_PULSE) && !is_merase && !is_perase;
  assign pulse_erase_out = (state == ftr_pkg::ST_PULSE) && (is_merase || is_perase);

  // read mux; aliases return the same copies
  always_comb begin
    rdata = 16'h0000;
    unique case (reg_addr_in)
      ftr_pkg::OFS_START:      rdata = {8'h00, start_delay_count};
      ftr_pkg::OFS_TRAN:       rdata = {8'h00, transition_count};
      ftr_pkg::OFS_PROG:       rdata = {8'h00, program_pulse_count};
      ftr_pkg::OFS_PERASE:     rdata = {8'h00, page_erase_count};
      ftr_pkg::OFS_MERASE:     rdata = {8'h00, module_erase_count};
      ftr_pkg::OFS_END:        rdata = {8'h00, end_delay_count};
      ftr_pkg::OFS_MEND:       rdata = {8'h00, module_end_delay_count};
      ftr_pkg::OFS_RCV:        rdata = {8'h00, recovery_delay_count};
      ftr_pkg::OFS_PSR:        rdata = {11'h000, prescale_divisor};
      ftr_pkg::OFS_FUNC,
      ftr_pkg::OFS_FUNC_ALIAS: rdata = function_word_copy;
      ftr_pkg::OFS_PROT,
      ftr_pkg::OFS_PROT_ALIAS: rdata = protection_word_copy;
      ftr_pkg::OFS_CODE,
      ftr_pkg::OFS_CODE_ALIAS: rdata = code_area_start;
      ftr_pkg::OFS_STATUS:     rdata = {13'h0000, busy, 2'h0};
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata;
    end
  end

  wire unused_ok = busy_at_reset;
endmodule
`default_nettype wire

// ---- verification/ftr_flash_timing_monitor.sv ----
// assertion checker for the flash timing register block
`default_nettype none
module ftr_flash_timing_monitor (
  input wire logic                       clk_sys_in,
  input wire logic                       rst_n_in,
  input wire logic [ftr_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic                       reg_rd_in,
  input wire logic [15:0]                reg_rdata_out,
  input wire logic                       op_start_in,
  input wire logic [15:0]                info_func_word_in,
  input wire logic [15:0]                info_prot_word_in,
  input wire logic                       usb_ctrl_power_in,
  input wire logic                       usb_xcvr_power_out,
  input wire logic                       flash_op_in_progress_out,
  input wire logic                       pulse_prog_out,
  input wire logic                       pulse_erase_out,
  input wire logic                       code_branch_valid_out,
  input wire logic [15:0]                code_area_start_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  wire logic pulse = pulse_prog_out | pulse_erase_out;
  wire logic valid = code_branch_valid_out;
  a_usb_power_gate: assert property (valid |->
    usb_xcvr_power_out == (info_func_word_in[0] & usb_ctrl_power_in)) else $error("usb power");
  a_code_zero_bits: assert property (valid |->
    code_area_start_out[8:0] == 9'h000 && code_area_start_out[15:13] == 3'h0) else $error("zero");
  a_code_boot_inv: assert property (valid |->
    code_area_start_out[12:9] == ~info_prot_word_in[4:1]) else $error("boot field");
  a_func_alias_read: assert property (reg_rd_in && valid &&
    reg_addr_in == ftr_pkg::OFS_FUNC_ALIAS |=> reg_rdata_out == info_func_word_in)
    else $error("func alias");
  a_prot_alias_read: assert property (reg_rd_in && valid &&
    reg_addr_in == ftr_pkg::OFS_PROT_ALIAS |=> reg_rdata_out == info_prot_word_in)
    else $error("prot alias");
  a_copies_loaded: assert property ($rose(rst_n_in) |-> ##[0:2] valid)
    else $error("copies late");
  a_start_busy: assert property (!flash_op_in_progress_out && op_start_in && valid
    |=> flash_op_in_progress_out) else $error("no busy");
  a_pulse_in_busy: assert property (pulse |-> flash_op_in_progress_out
    && !(pulse_prog_out && pulse_erase_out)) else $error("pulse outside busy");
  a_lead_before_pulse: assert property ($rose(flash_op_in_progress_out) |-> !pulse[*2])
    else $error("pulse too early");
  a_tail_after_pulse: assert property ($fell(pulse) |-> flash_op_in_progress_out[*2])
    else $error("busy dropped early");
  c_prog: cover property ($rose(pulse_prog_out));
  c_erase: cover property ($rose(pulse_erase_out));
  c_done: cover property ($fell(flash_op_in_progress_out));
endmodule
bind ftr_flash_timing ftr_flash_timing_monitor ftr_flash_timing_monitor_i (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .op_start_in(op_start_in),
  .info_func_word_in(info_func_word_in), .info_prot_word_in(info_prot_word_in),
  .usb_ctrl_power_in(usb_ctrl_power_in), .usb_xcvr_power_out(usb_xcvr_power_out),
  .flash_op_in_progress_out(flash_op_in_progress_out), .pulse_prog_out(pulse_prog_out),
  .pulse_erase_out(pulse_erase_out), .code_branch_valid_out(code_branch_valid_out),
  .code_area_start_out(code_area_start_out));
`default_nettype wire

// ---- verification/ftr_flash_array_model.sv ----
// flash array stand-in: info block words and phase length meter
`default_nettype none
module ftr_flash_array_model (
  input  wire logic        clk_sys_in,
  input  wire logic        alt_words_in,
  input  wire logic        op_start_in,
  input  wire logic        busy_in,
  input  wire logic        pulse_in,
  output logic      [15:0] func_word_out,
  output logic      [15:0] prot_word_out,
  output int               lead_out,
  output int               width_out,
  output int               tail_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic seen = 1'b0;
  // two word sets so both usb settings and two boot fields get seen
  assign func_word_out = alt_words_in ? 16'h5a30 : 16'h0001;
  assign prot_word_out = alt_words_in ? 16'h0008 : 16'h0016;
  // counts whole phases, so a one-cycle slip in any phase shows up
  always @(posedge clk_sys_in) begin
    if (op_start_in && !busy_in) begin
      seen <= 1'b0;
      lead_out <= 0;
      width_out <= 0;
      tail_out <= 0;
    end else if (pulse_in) begin
      seen <= 1'b1;
      width_out <= width_out + 1;
    end else if (busy_in && !seen) begin
      lead_out <= lead_out + 1;
    end else if (busy_in) begin
      tail_out <= tail_out + 1;
    end
  end
endmodule
`default_nettype wire

// ---- verification/ftr_flash_timing_test.sv ----
// self-checking bench for the flash timing register block
`default_nettype none
module ftr_flash_timing_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [3:0]  reg_addr_in = 4'h0;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic        op_start_in = 1'b0;
  logic [1:0]  op_kind_in = 2'h0;
  logic        usb_ctrl_in = 1'b0;
  logic        alt_words = 1'b0;
  wire logic [15:0] rdata, func_w, prot_w, code_out;
  wire logic        usb_x, busy, pp, pe, valid;
  wire logic [15:0] code_exp = {3'h0, ~prot_w[4:1], 9'h000};
  int lead, width, tail, errors = 0, compares = 0, cycles = 0;
  localparam logic [7:0] DEF_TBL [9] = '{8'h18, 8'h30, 8'h16, 8'h04, 8'hea, 8'h18, 8'h3c,
                                        8'h04, 8'h04};
  localparam logic [7:0] NEW_TBL [9] = '{8'h02, 8'h01, 8'h01, 8'h00, 8'h00, 8'h02, 8'h01,
                                        8'h01, 8'h01};
  always #2.5 clk_sys_in = ~clk_sys_in;
  ftr_flash_timing ftr_flash_timing_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(rdata), .op_start_in(op_start_in),
    .op_kind_in(op_kind_in), .info_func_word_in(func_w), .info_prot_word_in(prot_w),
    .usb_ctrl_power_in(usb_ctrl_in), .usb_xcvr_power_out(usb_x),
    .flash_op_in_progress_out(busy), .pulse_prog_out(pp), .pulse_erase_out(pe),
    .code_branch_valid_out(valid), .code_area_start_out(code_out));
  ftr_flash_array_model ftr_flash_array_model_i (.clk_sys_in(clk_sys_in),
    .alt_words_in(alt_words), .op_start_in(op_start_in), .busy_in(busy),
    .pulse_in(pp | pe), .func_word_out(func_w), .prot_word_out(prot_w),
    .lead_out(lead), .width_out(width), .tail_out(tail));
  task automatic summarize();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic do_reset(input logic alt);
    @(posedge clk_sys_in);
    alt_words <= alt;
    rst_n_in <= 1'b0;
    repeat (20) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 check(rdata, exp);
  endtask
  task automatic chk_words();
    rd_chk(ftr_pkg::OFS_FUNC, func_w);
    rd_chk(ftr_pkg::OFS_FUNC_ALIAS, func_w);
    rd_chk(ftr_pkg::OFS_PROT, prot_w);
    rd_chk(ftr_pkg::OFS_PROT_ALIAS, prot_w);
    rd_chk(ftr_pkg::OFS_CODE, code_exp);
    rd_chk(ftr_pkg::OFS_CODE_ALIAS, code_exp);
    check({15'h0000, valid}, 16'h0001);
    check(code_out, code_exp);
    @(posedge clk_sys_in);
    usb_ctrl_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    check({15'h0000, usb_x}, {15'h0000, func_w[0]});
    usb_ctrl_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    check({15'h0000, usb_x}, 16'h0000);
  endtask
  task automatic op_chk(input logic [1:0] k, input logic [15:0] l, w, t);
    int n;
    @(posedge clk_sys_in);
    op_kind_in <= k;
    op_start_in <= 1'b1;
    @(posedge clk_sys_in);
    op_start_in <= 1'b0;
    n = 0;
    rd_chk(ftr_pkg::OFS_STATUS, 16'h0004);
    // no register writes until busy clears
    while (busy !== 1'b0 && n < 20000) begin
      @(posedge clk_sys_in);
      #1 n++;
    end
    check(16'(lead), l);
    check(16'(width), w);
    check(16'(tail), t);
    rd_chk(ftr_pkg::OFS_STATUS, 16'h0000);
  endtask
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    do_reset(1'b0);
    for (int i = 0; i < 9; i++) rd_chk(4'(i), {8'h00, DEF_TBL[i]});
    chk_words();
    // junk upper byte must not stick in byte registers
    for (int i = 0; i < 9; i++) wr_reg(4'(i), {8'hff, NEW_TBL[i]});
    for (int i = 0; i < 9; i++) rd_chk(4'(i), {8'h00, NEW_TBL[i]});
    op_chk(ftr_pkg::OP_PROG, 16'h000a, 16'h0020, 16'h000a);
    wr_reg(ftr_pkg::OFS_PSR, 16'h0000);
    op_chk(ftr_pkg::OP_PERASE, 16'h0005, 16'h1000, 16'h0005);
    op_chk(ftr_pkg::OP_MERASE, 16'h0005, 16'h1000, 16'h0012);
    do_reset(1'b1);
    for (int i = 0; i < 9; i++) rd_chk(4'(i), {8'h00, DEF_TBL[i]});
    chk_words();
    summarize();
  end
endmodule
`default_nettype wire
